// ### hdl/cbsc_pkg.sv
package cbsc_pkg;

	typedef enum logic [2:0] {SRC_FLASH, SRC_JTAG, SRC_MSPI, SRC_SLAVE_SERIAL_CONFIG_MODE, SRC_I2C} cbsc_src_e;
	typedef enum logic [2:0] {PH_RESTORE, PH_IDLE, PH_LOAD, PH_CHECK, PH_USER} cbsc_phase_e;
	typedef enum logic {SED_IDLE, SED_RUN} cbsc_sed_e;

	localparam int NUM_SRC = 5;
	localparam int CFG_PINS = 10;
	localparam int TAP_PINS = 4;
	localparam int TAP_TDO = 3;
	localparam int BS_LEN = 8;
	localparam int SED_AW = 4;
	localparam logic [SED_AW-1:0] SED_LAST = 4'hf;
	// Soft-error checker advances one SRAM byte every SED_DIV reference cycles
	localparam int SED_DIV = 8;
	localparam logic [2:0] SED_DIV_MAX = 3'(SED_DIV - 1);
	// Arbitrary value, stands in for the factory part of the identifier
	localparam logic [55:0] ID_FACTORY = 56'h5a_a5_3c_c3_0f_f0_96;
	localparam logic [7:0] ID_USER_RST = 8'h00;
	localparam logic [15:0] CRC_INIT = 16'hffff;
	localparam logic [15:0] CRC_POLY = 16'h1021;
	// Locked until the non-volatile state is restored, the safe side
	localparam logic LOCK_RST = 1'b1;
	localparam logic OTP_RST = 1'b1;

	function automatic logic [15:0] cbsc_crc16(input logic [15:0] crc, input logic [7:0] b);
		logic [15:0] c;
		c = crc;
		for (int i = 7; i >= 0; i--) begin
			c = (c[15] ^ b[i]) ? ({c[14:0], 1'b0} ^ CRC_POLY) : {c[14:0], 1'b0};
		end
		return c;
	endfunction

	// Lowest index wins when several straps ask at once
	function automatic cbsc_src_e cbsc_pick(input logic [NUM_SRC-1:0] req);
		cbsc_src_e r;
		r = SRC_FLASH;
		for (int i = NUM_SRC - 1; i >= 0; i--) begin
			if (req[i]) begin
				r = cbsc_src_e'(3'(i));
			end
		end
		return r;
	endfunction

endpackage

// ### hdl/cbsc_top.sv
`timescale 1ns/1ps
// Functional notes
// - Configuration may come from flash, test port, SPI master, SPI slave or I2C.
// - The chosen source stays active and others are ignored until the cycle ends.
// - The test port activates whenever the tester sends its instruction after power-up.
// - Optional CRC check of the loaded image on entering user mode.
// - Boundary-scan cells form a shift chain with capture and update.
// - Four test-port pins act as general I/O when the test port is off.
// - Ten serial configuration pins revert to general I/O outside configuration.
// - Set readback lock refuses all readback; clear lock permits it.
// - Only a device erase or the power-up restore from nv_lock_i clears the readback lock.
// - OTP mode rejects erase or program of OTP regions.
// - Dual boot reloads from the golden image when the primary is corrupt.
// - Soft-error checker CRCs configuration SRAM after load, can be switched off.
// - In user mode a fabric input also starts a soft-error check.
// - Soft-error checker runs from a divider of the undivided oscillator clock.
// - 64-bit identifier, 56 factory bits and 8 user bits.
// - Identifier readable over bus, SPI, I2C and test port paths.
module cbsc_top import cbsc_pkg::*; (
	// Clock and reset
	input logic ref_clk,
	input logic rst,
	// Source selection and options
	input logic [NUM_SRC-1:0] src_req,
	input logic jtag_activate,
	input logic crc_check_en,
	input logic dual_boot_en,
	input logic sed_cfg_en,
	input logic sed_power_off,
	// Configuration byte stream
	input logic [7:0] cfg_byte,
	input cbsc_src_e cfg_byte_src,
	input logic cfg_byte_valid,
	input logic cfg_byte_last,
	input logic [15:0] cfg_crc_exp,
	output cbsc_src_e cfg_src,
	output logic cfg_busy,
	output logic user_mode,
	output logic golden_boot,
	// Serial configuration port pins
	input logic [CFG_PINS-1:0] cfgp_i,
	input logic [CFG_PINS-1:0] cfgp_eng_o,
	input logic [CFG_PINS-1:0] cfgp_eng_oe,
	input logic [CFG_PINS-1:0] cfgp_user_o,
	input logic [CFG_PINS-1:0] cfgp_user_oe,
	output logic [CFG_PINS-1:0] cfgp_o,
	output logic [CFG_PINS-1:0] cfgp_oe,
	output logic [CFG_PINS-1:0] cfgp_user_i,
	// Test port pins
	input logic test_port_enable_pin,
	input logic [TAP_PINS-1:0] tap_i,
	input logic [TAP_PINS-1:0] tap_gpio_o,
	input logic [TAP_PINS-1:0] tap_gpio_oe,
	output logic [TAP_PINS-1:0] tap_o,
	output logic [TAP_PINS-1:0] tap_oe,
	output logic [TAP_PINS-1:0] tap_gpio_i,
	output logic tap_active,
	// Boundary scan
	input logic bs_capture,
	input logic bs_shift,
	input logic bs_update,
	input logic bs_tdi,
	input logic [BS_LEN-1:0] bs_node_i,
	output logic [BS_LEN-1:0] bs_node_o,
	output logic bs_tdo,
	// Security
	input logic nv_lock_i,
	input logic nv_otp_i,
	input logic rb_req,
	input logic lock_set_req,
	input logic otp_set_req,
	input logic erase_req,
	input logic prog_req,
	input logic op_otp_region,
	output logic rb_grant,
	output logic rb_refused,
	output logic rb_locked,
	output logic otp_mode,
	output logic op_rejected,
	output logic erase_done,
	// Soft-error checker
	input logic sed_start_req,
	input logic [7:0] sram_data,
	output logic [SED_AW-1:0] sram_addr,
	output logic sed_busy,
	// Identifier
	input logic id_user_wr,
	input logic [7:0] id_user_data,
	input logic id_rd_req,
	input logic [1:0] id_rd_port,
	output logic [63:0] id_rd_data,
	output logic [1:0] id_rd_path,
	output logic id_rd_valid,
	// Status
	input logic status_clr,
	output logic cfg_crc_err,
	output logic sed_err
);

	typedef struct packed {
		logic [NUM_SRC-1:0] req_m;
		logic [NUM_SRC-1:0] req_s;
		logic tpe_m;
		logic tpe_s;
		logic [TAP_PINS-1:0] tap_m;
		logic [TAP_PINS-1:0] tap_s;
		logic [CFG_PINS-1:0] cfgp_m;
		logic [CFG_PINS-1:0] cfgp_s;
		logic [CFG_PINS-1:0] cfgp_o;
		logic [CFG_PINS-1:0] cfgp_oe;
		logic [TAP_PINS-1:0] tap_o;
		logic [TAP_PINS-1:0] tap_oe;
		cbsc_phase_e phase;
		cbsc_src_e src;
		logic golden;
		logic [15:0] crc;
		logic [15:0] exp;
		logic [15:0] sig;
		logic crc_err;
		logic tap_active;
		logic [BS_LEN-1:0] bs;
		logic [BS_LEN-1:0] bs_upd;
		logic lock;
		logic otp;
		logic rb_grant;
		logic rb_refused;
		logic op_rej;
		logic erase_done;
		logic [2:0] sed_div;
		cbsc_sed_e sed_st;
		logic sed_pend;
		logic [SED_AW-1:0] sed_addr;
		logic [15:0] sed_crc;
		logic sed_err;
		logic [7:0] id_user;
		logic [63:0] id_data;
		logic [1:0] id_path;
		logic id_valid;
	} cbsc_state_s;

	cbsc_state_s s_q, s_d;
	logic sed_tick;
	logic [15:0] load_nxt;
	logic [15:0] sed_nxt;
	logic port_owned;
	logic region_rej;

	assign sed_tick = (s_q.sed_div == 3'h0);
	assign load_nxt = cbsc_crc16(s_q.crc, cfg_byte);
	assign sed_nxt = cbsc_crc16(s_q.sed_crc, sram_data);
	assign port_owned = (s_q.phase == PH_LOAD || s_q.phase == PH_CHECK) &&
		(s_q.src == SRC_MSPI || s_q.src == SRC_SLAVE_SERIAL_CONFIG_MODE || s_q.src == SRC_I2C);
	assign region_rej = s_q.otp && op_otp_region;

	always_comb begin
		s_d = s_q;
		s_d.rb_grant = 1'b0;
		s_d.rb_refused = 1'b0;
		s_d.op_rej = 1'b0;
		s_d.erase_done = 1'b0;
		s_d.id_valid = 1'b0;
		s_d.req_m = src_req;
		s_d.req_s = s_q.req_m;
		s_d.tpe_m = test_port_enable_pin;
		s_d.tpe_s = s_q.tpe_m;
		s_d.tap_m = tap_i;
		s_d.tap_s = s_q.tap_m;
		s_d.cfgp_m = cfgp_i;
		s_d.cfgp_s = s_q.cfgp_m;
		// Clear first so a same-cycle event still sets the flag
		if (status_clr) begin
			s_d.crc_err = 1'b0;
			s_d.sed_err = 1'b0;
		end

		s_d.cfgp_o = port_owned ? cfgp_eng_o : cfgp_user_o;
		s_d.cfgp_oe = port_owned ? cfgp_eng_oe : cfgp_user_oe;
		s_d.tap_o = tap_gpio_o;
		s_d.tap_oe = tap_gpio_oe;
		if (s_q.tpe_s) begin
			s_d.tap_o = '0;
			s_d.tap_oe = '0;
			s_d.tap_o[TAP_TDO] = s_q.bs[0];
			s_d.tap_oe[TAP_TDO] = 1'b1;
		end

		if (jtag_activate && s_q.phase != PH_RESTORE) begin
			s_d.tap_active = 1'b1;
		end
		if (s_q.tap_active) begin
			if (bs_capture) begin
				s_d.bs = bs_node_i;
			end else if (bs_shift) begin
				s_d.bs = {bs_tdi, s_q.bs[BS_LEN-1:1]};
			end
			if (bs_update) begin
				s_d.bs_upd = s_q.bs;
			end
		end

		unique case (s_q.phase)
			PH_RESTORE: begin
				s_d.lock = nv_lock_i;
				s_d.otp = nv_otp_i;
				s_d.phase = PH_IDLE;
			end
			PH_IDLE, PH_USER: begin
				// A new source is only taken between cycles
				if (jtag_activate || (s_q.phase == PH_IDLE && |s_q.req_s)) begin
					s_d.src = jtag_activate ? SRC_JTAG : cbsc_pick(s_q.req_s);
					s_d.golden = 1'b0;
					s_d.crc = CRC_INIT;
					s_d.phase = PH_LOAD;
					s_d.sed_pend = 1'b0;
				end
			end
			PH_LOAD: begin
				if (cfg_byte_valid && cfg_byte_src == s_q.src) begin
					s_d.crc = load_nxt;
					if (cfg_byte_last) begin
						s_d.exp = cfg_crc_exp;
						s_d.sig = load_nxt;
						s_d.phase = crc_check_en ? PH_CHECK : PH_USER;
						s_d.sed_pend = !crc_check_en;
					end
				end
			end
			PH_CHECK: begin
				if (s_q.crc == s_q.exp) begin
					s_d.phase = PH_USER;
					s_d.sed_pend = 1'b1;
				end else begin
					s_d.crc_err = 1'b1;
					if (dual_boot_en && s_q.src == SRC_FLASH && !s_q.golden) begin
						// Golden copy is fetched from external SPI flash
						s_d.golden = 1'b1;
						s_d.src = SRC_MSPI;
						s_d.crc = CRC_INIT;
						s_d.phase = PH_LOAD;
					end else begin
						s_d.phase = PH_IDLE;
					end
				end
			end
			default: begin
				s_d.phase = PH_IDLE;
			end
		endcase

		if (rb_req) begin
			s_d.rb_grant = !s_q.lock;
			s_d.rb_refused = s_q.lock;
		end
		if ((erase_req || prog_req) && region_rej) begin
			s_d.op_rej = 1'b1;
		end else if (erase_req) begin
			s_d.lock = 1'b0;
			s_d.erase_done = 1'b1;
		end
		if (lock_set_req) begin
			s_d.lock = 1'b1;
		end
		if (otp_set_req) begin
			s_d.otp = 1'b1;
		end

		// Divider parked while the checker is off, to save power
		if (sed_power_off || sed_tick) begin
			s_d.sed_div = SED_DIV_MAX;
		end else begin
			s_d.sed_div = 3'(s_q.sed_div - 3'h1);
		end

		if (s_q.phase != PH_USER || sed_power_off || !sed_cfg_en) begin
			s_d.sed_st = SED_IDLE;
			s_d.sed_addr = '0;
		end else begin
			unique case (s_q.sed_st)
				SED_IDLE: begin
					if (s_q.sed_pend || sed_start_req) begin
						s_d.sed_st = SED_RUN;
						s_d.sed_pend = 1'b0;
						s_d.sed_addr = '0;
						s_d.sed_crc = CRC_INIT;
					end
				end
				SED_RUN: begin
					if (sed_tick) begin
						s_d.sed_crc = sed_nxt;
						s_d.sed_addr = SED_AW'(s_q.sed_addr + 4'h1);
						if (s_q.sed_addr == SED_LAST) begin
							s_d.sed_st = SED_IDLE;
							if (sed_nxt != s_q.sig) begin
								s_d.sed_err = 1'b1;
							end
						end
					end
				end
			endcase
		end

		if (id_user_wr) begin
			s_d.id_user = id_user_data;
		end
		if (id_rd_req) begin
			s_d.id_data = {ID_FACTORY, s_q.id_user};
			s_d.id_path = id_rd_port;
			s_d.id_valid = 1'b1;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			s_q <= '0;
			s_q.lock <= LOCK_RST;
			s_q.otp <= OTP_RST;
			s_q.sed_div <= SED_DIV_MAX;
			s_q.crc <= CRC_INIT;
			s_q.id_user <= ID_USER_RST;
		end else begin
			s_q <= s_d;
		end
	end

	assign cfg_src = s_q.src;
	assign cfg_busy = (s_q.phase == PH_LOAD || s_q.phase == PH_CHECK);
	assign user_mode = (s_q.phase == PH_USER);
	assign golden_boot = s_q.golden;
	assign cfgp_o = s_q.cfgp_o;
	assign cfgp_oe = s_q.cfgp_oe;
	assign cfgp_user_i = s_q.cfgp_s;
	assign tap_o = s_q.tap_o;
	assign tap_oe = s_q.tap_oe;
	assign tap_gpio_i = s_q.tap_s;
	assign tap_active = s_q.tap_active;
	assign bs_node_o = s_q.bs_upd;
	assign bs_tdo = s_q.bs[0];
	assign rb_grant = s_q.rb_grant;
	assign rb_refused = s_q.rb_refused;
	assign rb_locked = s_q.lock;
	assign otp_mode = s_q.otp;
	assign op_rejected = s_q.op_rej;
	assign erase_done = s_q.erase_done;
	assign sram_addr = s_q.sed_addr;
	assign sed_busy = (s_q.sed_st == SED_RUN);
	assign id_rd_data = s_q.id_data;
	assign id_rd_path = s_q.id_path;
	assign id_rd_valid = s_q.id_valid;
	assign cfg_crc_err = s_q.crc_err;
	assign sed_err = s_q.sed_err;

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	sequence s_crc_bad;
		s_q.phase == PH_CHECK && s_q.crc != s_q.exp;
	endsequence
	sequence s_golden_retry;
		s_q.phase == PH_LOAD && s_q.src == SRC_MSPI && s_q.golden;
	endsequence

	a_src_held_load: assert property (s_q.phase == PH_LOAD ##1 s_q.phase == PH_LOAD |-> $stable(s_q.src))
		else $error("source changed during load");
	a_foreign_byte: assert property (s_q.phase == PH_LOAD && cfg_byte_valid && cfg_byte_src != s_q.src
		|=> $stable(s_q.crc) && s_q.phase == PH_LOAD)
		else $error("byte from unselected source taken");
	a_tap_activate: assert property (s_q.phase != PH_RESTORE && jtag_activate |=> tap_active)
		else $error("test port not activated");
	a_crc_fail_flag: assert property (s_crc_bad |=> cfg_crc_err && !user_mode)
		else $error("bad CRC not flagged");
	a_bs_shift_chain: assert property ((tap_active && bs_shift && !bs_capture)[*8]
		|=> bs_tdo == $past(bs_tdi, 8))
		else $error("scan chain length wrong");
	a_tap_gpio_mode: assert property (!s_q.tpe_s |=> tap_oe == $past(tap_gpio_oe))
		else $error("test pins not released to user");
	a_cfg_pin_user: assert property (user_mode |=> cfgp_oe == $past(cfgp_user_oe))
		else $error("config pins not released to user");
	a_rb_locked: assert property (rb_req && rb_locked |=> rb_refused && !rb_grant)
		else $error("readback not refused");
	a_lock_hold: assert property (rb_locked && s_q.phase != PH_RESTORE
		&& !(erase_req && !region_rej) |=> rb_locked)
		else $error("lock cleared without erase");
	a_otp_reject: assert property (region_rej && (erase_req || prog_req)
		|=> op_rejected && !erase_done && $stable(rb_locked))
		else $error("OTP region change not rejected");
	a_golden_retry: assert property (s_crc_bad ##0 (dual_boot_en && s_q.src == SRC_FLASH
		&& !s_q.golden) |=> s_golden_retry)
		else $error("golden reload not started");
	a_sed_start: assert property (user_mode && sed_cfg_en && !sed_power_off && !sed_busy
		&& sed_start_req |=> sed_busy && sram_addr == 4'h0)
		else $error("fabric check request ignored");
	a_sed_tick_gap: assert property (sed_tick ##1 (!sed_power_off)[*8]
		|-> sed_tick && !$past(sed_tick))
		else $error("checker divider period wrong");
	a_id_read: assert property (id_rd_req |=> id_rd_valid && id_rd_data[63:8] == ID_FACTORY)
		else $error("identifier read wrong");

endmodule // cbsc_top

// ### test/cbsc_host_model.sv
`timescale 1ns/1ps
// Far side of the stream: tester, host or boot flash sending one 16-byte image
module cbsc_host_model import cbsc_pkg::*; (
	// Clock and reset
	input logic ref_clk,
	input logic rst,
	// Control from the bench
	input logic hgo,
	input logic hbad,
	input logic hslow,
	input cbsc_src_e hsrc,
	input logic [127:0] image,
	input logic [15:0] hcrc,
	// Byte stream
	output logic [7:0] cfg_byte,
	output cbsc_src_e cfg_byte_src,
	output logic cfg_byte_valid,
	output logic cfg_byte_last,
	output logic [15:0] cfg_crc_exp,
	output logic hbusy
);
	int idx;
	logic ph;
	initial {cfg_byte, cfg_byte_src, cfg_byte_valid, cfg_byte_last, cfg_crc_exp, hbusy, ph} = '0;
	always @(posedge ref_clk) begin
		if (!rst && hbusy && (!hslow || ph)) begin
			// Corruption is in transit only; the expected check value stays true
			cfg_byte <= image[idx*8 +: 8] ^ {7'h00, hbad && idx == 3};
			cfg_byte_src <= hsrc;
			cfg_byte_valid <= 1'h1;
			cfg_byte_last <= idx == 15;
			cfg_crc_exp <= hcrc;
			idx <= idx + 1;
		end else begin
			// Idle data toggles so a stale byte never reads as fresh
			cfg_byte <= ~cfg_byte;
			cfg_byte_valid <= 1'h0;
			cfg_byte_last <= 1'h0;
		end
		if (rst) begin
			hbusy <= 1'h0;
		end else if (hgo && !hbusy) begin
			hbusy <= 1'h1;
			idx <= 0;
		end else if (hbusy) begin
			ph <= ~ph;
			if ((!hslow || ph) && idx == 15) begin
				hbusy <= 1'h0;
			end
		end
	end
endmodule // cbsc_host_model

// ### test/cbsc_top_bench.sv
`timescale 1ns/1ps
`define CHK(n, e, a) begin n_tests++; if ((e) !== (a)) begin err_count++; \
	$display("MISMATCH %s exp %0h got %0h", n, e, a); end end
`define WT(c) while (!(c)) begin @(posedge ref_clk); #1; end
module cbsc_top_bench import cbsc_pkg::*;;
	logic ref_clk = 1'h0;
	logic rst = 1'h1;
	logic [4:0] src_req = '0;
	logic crc_check_en = 1'h1, sed_cfg_en = 1'h1, dual_boot_en = '0, sed_power_off = '0;
	logic [9:0] pr = '0;
	logic op_otp_region = '0, nv_lock_i = '0, nv_otp_i = '0, test_port_enable_pin = '0;
	logic [9:0] cfgp_i = '0, cfgp_eng_o = '0, cfgp_eng_oe = '0, cfgp_user_o = '0, cfgp_user_oe = '0;
	logic [3:0] tap_i = '0, tap_gpio_o = '0, tap_gpio_oe = '0;
	logic bs_capture = '0, bs_shift = '0, bs_update = '0, bs_tdi = '0;
	logic [7:0] bs_node_i = '0, id_user_data = '0, sram_data, cfg_byte, bs_node_o;
	logic [1:0] id_rd_port = '0, id_rd_path;
	logic hgo = '0, hbad = '0, hslow = '0, hbusy;
	cbsc_src_e hsrc = SRC_FLASH, cfg_byte_src, cfg_src;
	logic [127:0] image = '0;
	logic [15:0] hcrc = '0, cfg_crc_exp;
	logic cfg_byte_valid, cfg_byte_last, cfg_busy, user_mode, golden_boot, tap_active, bs_tdo;
	logic rb_grant, rb_refused, rb_locked, otp_mode, op_rejected, erase_done, sed_busy;
	logic id_rd_valid, cfg_crc_err, sed_err;
	logic [9:0] cfgp_o, cfgp_oe, cfgp_user_i;
	logic [3:0] tap_o, tap_oe, tap_gpio_i, sram_addr;
	logic [63:0] id_rd_data;
	logic [7:0] sram [16];
	logic [4:0] seen;
	// System side parks the right-side PLL while flash is programmed in the background
	logic right_side_pll_rst = 1'h0;
	logic [31:0] rs = 32'h0000_9bbc;
	int err_count = 0, n_tests = 0, cyc = 0;
	wire [4:0] po = {id_rd_valid, op_rejected, erase_done, rb_refused, rb_grant};

	cbsc_top dut (.*, .rb_req(pr[0]), .lock_set_req(pr[1]), .otp_set_req(pr[2]),
		.erase_req(pr[3]), .prog_req(pr[4]), .id_rd_req(pr[5]), .sed_start_req(pr[6]),
		.status_clr(pr[7]), .id_user_wr(pr[8]), .jtag_activate(pr[9]));
	cbsc_host_model host (.*);

	always #2 ref_clk = ~ref_clk;
	assign sram_data = sram[sram_addr];

	task automatic conclude();
		if (err_count == 0 && n_tests > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask

	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 6000) begin
			err_count++;
			conclude();
		end
	end

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	function automatic int crc(input int c, input int b);
		for (int i = 7; i >= 0; i--) begin
			c = ((c >> 15 ^ b >> i) & 1) ? (c << 1 ^ 16'h1021) & 16'hffff : c << 1 & 16'hffff;
		end
		return c;
	endfunction

	// Pulse one request; catch an answer pulse in either of the next two cycles
	task automatic pls(input int i);
		@(posedge ref_clk) pr[i] <= 1'h1;
		@(posedge ref_clk) pr[i] <= 1'h0;
		#1 seen = po;
		@(posedge ref_clk) #1 seen |= po;
	endtask

	task automatic load(input cbsc_src_e s, input logic b);
		int c;
		c = 16'hffff;
		for (int k = 0; k < 16; k++) begin
			rs = lfsr(rs);
			image[k*8 +: 8] = rs[7:0];
			sram[k] = rs[7:0];
			c = crc(c, rs[7:0]);
		end
		@(posedge ref_clk) begin
			hsrc <= s;
			hbad <= b;
			hcrc <= c[15:0];
			hslow <= rs[8];
			hgo <= 1'h1;
		end
		@(posedge ref_clk) hgo <= 1'h0;
		#1 `WT(!hbusy)
	endtask

	initial begin
		repeat (20) @(posedge ref_clk);
		#1 `CHK("rst lock", 1'h1, rb_locked)
		`CHK("rst otp", 1'h1, otp_mode)
		@(posedge ref_clk) rst <= 1'h0;
		repeat (3) @(posedge ref_clk);
		#1 `CHK("unlocked", 1'h0, rb_locked)
		@(posedge ref_clk) src_req <= 5'h08;
		`WT(cfg_busy === 1'h1)
		`CHK("src", SRC_SLAVE_SERIAL_CONFIG_MODE, cfg_src)
		@(posedge ref_clk) src_req <= 5'h10;
		load(SRC_SLAVE_SERIAL_CONFIG_MODE, 1'h0);
		`WT(user_mode === 1'h1)
		`CHK("src kept", SRC_SLAVE_SERIAL_CONFIG_MODE, cfg_src)
		`CHK("crc ok", 1'h0, cfg_crc_err)
		@(posedge ref_clk) src_req <= 5'h00;
		`WT(sed_busy === 1'h1)
		`WT(sed_busy === 1'h0)
		`CHK("sed clean", 1'h0, sed_err)
		sram[5] = ~sram[5];
		pls(6);
		`CHK("sed start", 1'h1, sed_busy)
		`WT(sed_busy === 1'h0)
		`CHK("sed err", 1'h1, sed_err)
		pls(7);
		`CHK("clear", 1'h0, sed_err)
		pls(6);
		@(posedge ref_clk) sed_power_off <= 1'h1;
		repeat (3) @(posedge ref_clk);
		#1 `CHK("sed off", 2'h0, {sed_busy, sed_err})
		pls(0);
		`CHK("grant", 2'h1, seen[1:0])
		pls(1);
		`CHK("lock", 1'h1, rb_locked)
		pls(0);
		`CHK("refuse", 2'h2, seen[1:0])
		@(posedge ref_clk) right_side_pll_rst <= 1'h1;
		pls(4);
		`CHK("prog keeps", 1'h1, rb_locked)
		right_side_pll_rst <= 1'h0;
		pls(3);
		`CHK("erase", 2'h1, {rb_locked, seen[2]})
		pls(2);
		`CHK("otp", 1'h1, otp_mode)
		@(posedge ref_clk) op_otp_region <= 1'h1;
		for (int k = 3; k < 5; k++) begin
			pls(k);
			`CHK("otp reject", 2'h2, seen[3:2])
		end
		rs = lfsr(rs);
		@(posedge ref_clk) id_user_data <= rs[7:0];
		pls(8);
		for (int k = 0; k < 4; k++) begin
			@(posedge ref_clk) id_rd_port <= k[1:0];
			pls(5);
			`CHK("id", {ID_FACTORY, rs[7:0]}, id_rd_data)
			`CHK("id path", {1'h1, k[1:0]}, {seen[4], id_rd_path})
		end
		rs = lfsr(rs);
		@(posedge ref_clk) begin
			cfgp_user_o <= rs[9:0];
			cfgp_user_oe <= rs[19:10];
			cfgp_i <= rs[29:20];
			cfgp_eng_o <= ~rs[9:0];
			cfgp_eng_oe <= ~rs[19:10];
			tap_gpio_o <= rs[3:0];
			tap_gpio_oe <= rs[7:4];
			tap_i <= rs[11:8];
		end
		repeat (4) @(posedge ref_clk);
		#1 `CHK("cfg pins", rs[19:0], {cfgp_oe, cfgp_o})
		`CHK("cfg pins in", rs[29:20], cfgp_user_i)
		`CHK("tap gpio", rs[11:0], {tap_gpio_i, tap_oe, tap_o})
		@(posedge ref_clk) test_port_enable_pin <= 1'h1;
		repeat (4) @(posedge ref_clk);
		#1 `CHK("tap owned", 4'h8, tap_oe)
		pls(9);
		`CHK("tap on", {1'h1, SRC_JTAG}, {tap_active, cfg_src})
		rs = lfsr(rs);
		@(posedge ref_clk) begin
			bs_node_i <= rs[15:8];
			bs_capture <= 1'h1;
		end
		@(posedge ref_clk) bs_capture <= 1'h0;
		@(posedge ref_clk) #1 `CHK("capture", rs[8], bs_tdo)
		for (int k = 0; k < 8; k++) @(posedge ref_clk) begin
			bs_shift <= 1'h1;
			bs_tdi <= rs[k];
		end
		@(posedge ref_clk) bs_shift <= 1'h0;
		@(posedge ref_clk) bs_update <= 1'h1;
		@(posedge ref_clk) bs_update <= 1'h0;
		@(posedge ref_clk) #1 `CHK("scan out", rs[0], bs_tdo)
		`CHK("update", rs[7:0], bs_node_o)
		load(SRC_JTAG, 1'h1);
		`WT(user_mode === 1'h1 || cfg_crc_err === 1'h1)
		`CHK("crc bad", 1'h1, cfg_crc_err)
		@(posedge ref_clk) begin
			rst <= 1'h1;
			nv_lock_i <= 1'h1;
			dual_boot_en <= 1'h1;
			src_req <= 5'h01;
		end
		repeat (3) @(posedge ref_clk);
		rst <= 1'h0;
		repeat (3) @(posedge ref_clk);
		#1 `CHK("nv lock", 1'h1, rb_locked)
		`WT(cfg_busy === 1'h1)
		load(SRC_FLASH, 1'h1);
		`WT(golden_boot === 1'h1)
		`CHK("golden src", SRC_MSPI, cfg_src)
		@(posedge ref_clk) crc_check_en <= 1'h0;
		#1 `CHK("cfg pins owned", {cfgp_eng_oe, cfgp_eng_o}, {cfgp_oe, cfgp_o})
		load(SRC_MSPI, 1'h0);
		`WT(user_mode === 1'h1)
		`CHK("golden done", {1'h1, SRC_MSPI}, {golden_boot, cfg_src})
		conclude();
	end
endmodule // cbsc_top_bench
